/* File: core/dgoc_pkg.sv */
// Package with register layout, reset values and calibration constants
package dgoc_pkg;
  localparam int DGOC_DW = 16;
  localparam int DGOC_MW = 8;
  localparam logic [15:0] DGOC_OFFSET_RST = 16'h8000;
  localparam logic [15:0] DGOC_GAIN_RST = 16'hffff;
  localparam logic [16:0] DGOC_OFFSET_MID = 17'h08000;
  localparam logic [15:0] DGOC_CODE_MAX = 16'hffff;
  localparam logic [15:0] DGOC_CODE_MIN = 16'h0000;
  localparam int DGOC_GAIN_SHIFT = 16;
  // Register select codes on the host register port
  localparam logic [1:0] DGOC_SEL_OFFSET = 2'h0;
  localparam logic [1:0] DGOC_SEL_GAIN = 2'h1;
  localparam logic [1:0] DGOC_SEL_DAC = 2'h2;
  // Monitor source select values
  localparam logic DGOC_MON_LOOP = 1'b0;
  localparam logic DGOC_MON_TEMP = 1'b1;
  typedef enum logic [1:0] {
    DGOC_ST_IDLE = 2'b00,
    DGOC_ST_MUL = 2'b01,
    DGOC_ST_ADD = 2'b10
  } dgoc_state_t;
endpackage

/* File: core/dgoc_gain_mul.sv */
// Registered gain multiplier: scaled = code * gain / 2^16
`timescale 1ns/1ps
module dgoc_gain_mul
  import dgoc_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic [W-1:0] code_in,
  input wire logic [W-1:0] gain_in,
  output logic [W-1:0] scaled_out
);
  logic [2*W-1:0] prod;

  // Full product, upper half kept
  assign prod = (2*W)'(code_in) * (2*W)'(gain_in);

  // Truncating divide by 2^16
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scaled_out <= '0;
    end else begin
      scaled_out <= prod[DGOC_GAIN_SHIFT +: W];
    end
  end
endmodule // dgoc_gain_mul

/* File: core/dgoc_cal.sv */
// Gain and offset calibration path with monitor code selection
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module dgoc_cal
  import dgoc_pkg::*;
#(
  parameter int W = DGOC_DW,
  parameter int MW = DGOC_MW
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic wr_en_in,
  input wire logic [1:0] wr_sel_in,
  input wire logic [W-1:0] wr_data_in,
  input wire logic [1:0] rd_sel_in,
  input wire logic mon_sel_in,
  input wire logic [MW-1:0] loop_sense_input,
  input wire logic [MW-1:0] temp_code_in,
  output logic [W-1:0] rd_data_out,
  output logic [W-1:0] cal_code_out,
  output logic cal_valid_out,
  output logic [MW-1:0] mon_code_out
);
  logic [W-1:0] offset_trim_r;
  logic [W-1:0] gain_trim_r;
  logic [W-1:0] dac_code_r;
  logic [W-1:0] scaled;
  logic [W-1:0] cal_nxt;
  logic [W-1:0] rd_nxt;
  logic [MW-1:0] mon_nxt;
  dgoc_state_t state_r;

  // Signed sum of scaled code and biased offset, saturated to 16 bits
  function automatic logic [W-1:0] dgoc_sat(input logic [W-1:0] s, input logic [W-1:0] o);
    logic signed [W+2:0] sum;
    sum = $signed({3'b000, s}) + $signed({3'b000, o}) - $signed({2'b00, DGOC_OFFSET_MID});
    if (sum < $signed({3'b000, s}) && s == DGOC_CODE_MIN) begin
      dgoc_sat = DGOC_CODE_MIN;
    end else if (sum[W+2]) begin
      dgoc_sat = DGOC_CODE_MIN;
    end else if (sum > $signed({3'b000, DGOC_CODE_MAX})) begin
      dgoc_sat = DGOC_CODE_MAX;
    end else begin
      dgoc_sat = sum[W-1:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Trim and DAC code registers
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      offset_trim_r <= DGOC_OFFSET_RST;
      gain_trim_r <= DGOC_GAIN_RST;
      dac_code_r <= '0;
    end else if (wr_en_in) begin
      case (wr_sel_in)
        DGOC_SEL_OFFSET: offset_trim_r <= wr_data_in;
        DGOC_SEL_GAIN: gain_trim_r <= wr_data_in;
        DGOC_SEL_DAC: dac_code_r <= wr_data_in;
        default: ;
      endcase
    end
  end

  // Readback mux
  always_comb begin
    case (rd_sel_in)
      DGOC_SEL_OFFSET: rd_nxt = offset_trim_r;
      DGOC_SEL_GAIN: rd_nxt = gain_trim_r;
      DGOC_SEL_DAC: rd_nxt = dac_code_r;
      default: rd_nxt = '0;
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain stage
  dgoc_gain_mul #(.W(W)) u_mul (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .code_in(dac_code_r),
    .gain_in(gain_trim_r),
    .scaled_out(scaled)
  );

  // Sequencer: restart on any write, result two cycles later
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= DGOC_ST_IDLE;
    end else begin
      case (state_r)
        DGOC_ST_IDLE: state_r <= wr_en_in ? DGOC_ST_MUL : DGOC_ST_IDLE;
        DGOC_ST_MUL: state_r <= wr_en_in ? DGOC_ST_MUL : DGOC_ST_ADD;
        DGOC_ST_ADD: state_r <= wr_en_in ? DGOC_ST_MUL : DGOC_ST_IDLE;
        default: state_r <= DGOC_ST_IDLE;
      endcase
    end
  end

  // Offset add and clamp
  assign cal_nxt = dgoc_sat(scaled, offset_trim_r);

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cal_code_out <= DGOC_CODE_MIN;
      cal_valid_out <= 1'b0;
    end else begin
      cal_code_out <= cal_nxt;
      cal_valid_out <= !wr_en_in && (state_r == DGOC_ST_ADD || state_r == DGOC_ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Monitor field source select
  assign mon_nxt = (mon_sel_in == DGOC_MON_TEMP) ? temp_code_in : loop_sense_input;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mon_code_out <= '0;
    end else begin
      mon_code_out <= mon_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_reset_vals;
    @(posedge mclk_in) $rose(arst_n_in) |-> offset_trim_r == DGOC_OFFSET_RST
      && gain_trim_r == DGOC_GAIN_RST;
  endproperty
  trim_reset_a: assert property (p_reset_vals) else $error("trim reset value wrong");

  offset_write_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    wr_en_in && wr_sel_in == DGOC_SEL_OFFSET |=> offset_trim_r == $past(wr_data_in))
    else $error("offset write lost");

  gain_write_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    wr_en_in && wr_sel_in == DGOC_SEL_GAIN |=> gain_trim_r == $past(wr_data_in))
    else $error("gain write lost");

  sequence s_wr_gain;
    wr_en_in && wr_sel_in == DGOC_SEL_GAIN;
  endsequence
  sequence s_quiet2;
    !wr_en_in [*2];
  endsequence
  readback_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    s_wr_gain ##1 (rd_sel_in == DGOC_SEL_GAIN) |=> rd_data_out == $past(wr_data_in, 2))
    else $error("gain readback wrong");

  unity_gain_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    (wr_en_in == 1'b0)[*3] ##0 (gain_trim_r == DGOC_GAIN_RST)
    && (offset_trim_r == DGOC_OFFSET_MID[W-1:0]) && dac_code_r == DGOC_CODE_MIN
    |=> cal_code_out == DGOC_CODE_MIN)
    else $error("zero code not zero");

  zero_floor_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    scaled == DGOC_CODE_MIN && offset_trim_r < DGOC_OFFSET_MID[W-1:0]
    |=> cal_code_out == DGOC_CODE_MIN)
    else $error("zero scale pulled low");

  sat_low_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    {1'b0, scaled} + {1'b0, offset_trim_r} < DGOC_OFFSET_MID
    |=> cal_code_out == DGOC_CODE_MIN)
    else $error("output wrapped low");

  offset_bias_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    scaled == DGOC_CODE_MIN && offset_trim_r >= DGOC_OFFSET_MID[W-1:0]
    |=> cal_code_out == $past(offset_trim_r) - DGOC_OFFSET_MID[W-1:0])
    else $error("offset bias wrong");

  offset_hold_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    !(wr_en_in && wr_sel_in == DGOC_SEL_OFFSET) |=> $stable(offset_trim_r))
    else $error("offset trim changed without a write");

  gain_hold_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    !(wr_en_in && wr_sel_in == DGOC_SEL_GAIN) |=> $stable(gain_trim_r))
    else $error("gain trim changed without a write");

  // Saturation when the biased sum passes full scale
  sat_high_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    {1'b0, scaled} + {1'b0, offset_trim_r} > {1'b0, DGOC_CODE_MAX} + DGOC_OFFSET_MID
    |=> cal_code_out == DGOC_CODE_MAX)
    else $error("output wrapped high");

  valid_after_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    wr_en_in ##1 s_quiet2 |=> cal_valid_out)
    else $error("result not valid in time");

  mon_sel_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    mon_sel_in == DGOC_MON_TEMP |=> mon_code_out == $past(temp_code_in))
    else $error("monitor source wrong");

  mon_loop_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    mon_sel_in == DGOC_MON_LOOP |=> mon_code_out == $past(loop_sense_input))
    else $error("monitor loop source wrong");

  // Result flag drops on every write edge
  valid_low_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    wr_en_in |=> !cal_valid_out)
    else $error("valid stayed high over a write");

  dac_write_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    wr_en_in && wr_sel_in == DGOC_SEL_DAC |=> dac_code_r == $past(wr_data_in))
    else $error("code write lost");

  rd_offset_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    rd_sel_in == DGOC_SEL_OFFSET |=> rd_data_out == $past(offset_trim_r))
    else $error("offset readback wrong");
endmodule // dgoc_cal

/* File: tb/dgoc_host_model.sv */
// Host microcontroller model for the calibration register port
`timescale 1ns/1ps
module dgoc_host_model (
  input wire logic mclk_in,
  input wire logic [15:0] rd_data_in,
  output logic wr_en_out,
  output logic [1:0] wr_sel_out,
  output logic [15:0] wr_data_out,
  output logic [1:0] rd_sel_out
);
  // Port idle at time zero
  initial begin
    wr_en_out = 1'b0;
    wr_sel_out = 2'h3;
    wr_data_out = 16'h0000;
    rd_sel_out = 2'h3;
  end
  // One-cycle write strobe, data scrambled once released
  task automatic wr(input logic [1:0] s, input logic [15:0] d);
    @(negedge mclk_in);
    wr_en_out = 1'b1;
    wr_sel_out = s;
    wr_data_out = d;
    @(negedge mclk_in);
    wr_en_out = 1'b0;
    wr_data_out = ~d;
  endtask
  // Readback lands one cycle after the select
  task automatic rd(input logic [1:0] s, output logic [15:0] q);
    @(negedge mclk_in);
    rd_sel_out = s;
    @(negedge mclk_in);
    q = rd_data_in;
  endtask
  // Monitor code to loop volts and die temperature
  function automatic real volts(input logic [7:0] d);
    return 2.5 / 256.0 * d;
  endfunction
  function automatic real temp_c(input logic [7:0] d);
    return -1.559 * d + 312.0;
  endfunction
endmodule // dgoc_host_model

/* File: tb/dgoc_cal_tb.sv */
// Self-checking bench for the gain and offset calibration path
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module dgoc_cal_tb;
  import dgoc_pkg::*;
  logic mclk_in;
  logic arst_n_in;
  logic mon_sel_in;
  logic [7:0] loop_s;
  logic [7:0] temp_s;
  logic wr_en, cal_valid;
  logic [1:0] wr_sel, rd_sel;
  logic [15:0] wr_data, rd_data, cal_code, q;
  logic [7:0] mon_code;
  int failures = 0;
  int n_checks = 0;
  dgoc_host_model u_host (.mclk_in(mclk_in), .rd_data_in(rd_data), .wr_en_out(wr_en),
    .wr_sel_out(wr_sel), .wr_data_out(wr_data), .rd_sel_out(rd_sel));
  dgoc_cal u_dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .wr_en_in(wr_en),
    .wr_sel_in(wr_sel), .wr_data_in(wr_data), .rd_sel_in(rd_sel), .mon_sel_in(mon_sel_in),
    .loop_sense_input(loop_s), .temp_code_in(temp_s), .rd_data_out(rd_data),
    .cal_code_out(cal_code), .cal_valid_out(cal_valid), .mon_code_out(mon_code));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // Verdict and end of run
  task automatic end_sim();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Expected calibrated code, saturated to 16 bits
  function automatic logic [15:0] exp_cal(input longint d, g, o);
    longint v;
    v = ((d * g) >> 16) + o - 32768;
    return (v < 0) ? 16'h0000 : (v > 65535) ? 16'hffff : v[15:0];
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and unused readback select
  task automatic t_reset();
    u_host.rd(DGOC_SEL_OFFSET, q);
    `CHK(q, 16'h8000)
    u_host.rd(DGOC_SEL_GAIN, q);
    `CHK(q, 16'hffff)
    u_host.rd(2'h3, q);
    `CHK(q, 16'h0000)
  endtask
  // Full-width write and readback, select 3 ignored
  task automatic t_regs();
    u_host.wr(DGOC_SEL_OFFSET, 16'ha5c3);
    u_host.wr(DGOC_SEL_GAIN, 16'h5a3c);
    u_host.wr(2'h3, 16'h1234);
    u_host.rd(DGOC_SEL_OFFSET, q);
    `CHK(q, 16'ha5c3)
    u_host.rd(DGOC_SEL_GAIN, q);
    `CHK(q, 16'h5a3c)
    u_host.rd(DGOC_SEL_DAC, q);
    `CHK(q, 16'h0000)
  endtask
  // Reset in mid-run restores the trims and clears the outputs
  task automatic t_rst_mid();
    `CHK(cal_code, 16'h25c3)
    @(negedge mclk_in);
    arst_n_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    `CHK(cal_valid, 1'b0)
    `CHK(rd_data, 16'h0000)
    arst_n_in = 1'b1;
    u_host.rd(DGOC_SEL_OFFSET, q);
    `CHK(q, 16'h8000)
    u_host.rd(DGOC_SEL_GAIN, q);
    `CHK(q, 16'hffff)
    `CHK(cal_code, 16'h0000)
    `CHK(cal_valid, 1'b1)
  endtask
  // Trims and code written with one idle cycle between writes, then wait for the result
  task automatic t_cal(input logic [15:0] d, g, o);
    int i;
    u_host.wr(DGOC_SEL_GAIN, g);
    u_host.wr(DGOC_SEL_OFFSET, o);
    u_host.wr(DGOC_SEL_DAC, d);
    `CHK(cal_valid, 1'b0)
    for (i = 0; i < 8 && cal_valid !== 1'b1; i++) @(negedge mclk_in);
    if (i == 8) begin
      failures++;
      end_sim();
    end
    `CHK(i, 2)
    `CHK(cal_code, exp_cal(d, g, o))
  endtask
  // Monitor source selection
  task automatic t_mon();
    loop_s = 8'h3c;
    temp_s = 8'hc5;
    mon_sel_in = DGOC_MON_LOOP;
    repeat (2) @(negedge mclk_in);
    `CHK(mon_code, 8'h3c)
    mon_sel_in = DGOC_MON_TEMP;
    repeat (2) @(negedge mclk_in);
    `CHK(mon_code, 8'hc5)
    temp_s = 8'h00;
    repeat (2) @(negedge mclk_in);
    `CHK(int'(u_host.temp_c(mon_code)), 312)
    temp_s = 8'hff;
    repeat (2) @(negedge mclk_in);
    `CHK(int'(u_host.temp_c(mon_code)), -86)
    loop_s = 8'hff;
    mon_sel_in = DGOC_MON_LOOP;
    repeat (2) @(negedge mclk_in);
    `CHK(int'(u_host.volts(mon_code) * 100.0), 249)
    loop_s = 8'h00;
    repeat (2) @(negedge mclk_in);
    `CHK(int'(u_host.volts(mon_code) * 100.0), 0)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    arst_n_in = 1'b0;
    mon_sel_in = 1'b0;
    loop_s = 8'h00;
    temp_s = 8'h00;
    repeat (10) @(negedge mclk_in);
    arst_n_in = 1'b1;
    t_reset();
    t_regs();
    t_rst_mid();
    t_cal(16'h1234, 16'hffff, 16'h8000);
    t_cal(16'hffff, 16'h8000, 16'h8000);
    t_cal(16'h4000, 16'hffff, 16'hffff);
    t_cal(16'h0000, 16'hffff, 16'h0000);
    t_cal(16'hffff, 16'hffff, 16'hffff);
    t_cal(16'h0010, 16'h0001, 16'h7000);
    t_mon();
    end_sim();
  end
endmodule // dgoc_cal_tb
